/* File: rtl/monitor_regs_pkg.sv */
// Purpose: constants for the monitor rate, trim and result register slice
// Assumes: 16-bit register words, 7-bit register addresses
// Notes:   field positions differ between the serial and two-wire host ports
package monitor_regs_pkg;
  localparam logic [6:0]  ADDR_CONV_SPEED    = 7'h0B;
  localparam logic [6:0]  ADDR_TRIM1         = 7'h21;
  localparam logic [6:0]  ADDR_TRIM2         = 7'h22;
  localparam logic [6:0]  ADDR_RESULT_FIRST  = 7'h23;
  localparam logic [6:0]  ADDR_RESULT_LAST   = 7'h32;
  localparam int          SPEED_LSB_SPI      = 0;
  localparam int          SPEED_LSB_I2C      = 8;
  localparam int          TRIM_LSB_SPI       = 0;
  localparam int          TRIM_LSB_I2C       = 8;
  localparam logic [15:0] CONV_SPEED_RST_SPI = 16'h0007;
  localparam logic [15:0] CONV_SPEED_RST_I2C = 16'h07FF;
  localparam logic [15:0] TRIM_RST_SPI       = 16'h0000;
  localparam logic [15:0] TRIM_RST_I2C       = 16'h00FF;
  localparam logic [2:0]  SPEED_BASE         = 3'h7;
  localparam logic [11:0] RESULT_RST         = 12'h000;
  localparam int          RESULT_COUNT       = 16;
  localparam longint      CLK_HZ             = 125000000;
  // monitoring cycle times in ms
  localparam longint CYC_MS_LOCAL      = 15;
  localparam longint CYC_MS_ONE        = 44;
  localparam longint CYC_MS_ONE_RC     = 93;
  localparam longint CYC_MS_ONE_LOC    = 59;
  localparam longint CYC_MS_ONE_LOC_RC = 108;
  localparam longint CYC_MS_TWO        = 88;
  localparam longint CYC_MS_TWO_RC     = 186;
  localparam longint CYC_MS_ALL        = 103;
  localparam longint CYC_MS_ALL_RC     = 201;
  localparam longint MS_CYCLES         = CLK_HZ / 1000;
endpackage

/* File: rtl/cycle_timer.sv */
// Purpose: free-running monitoring cycle counter with a pulse at each wrap
// Assumes: period given in clock cycles, at least 1
// Notes:   a shorter period takes effect at once; counter restarts past it
`timescale 1ns/1ps
module cycle_timer (
  input  wire logic        clk,     // system clock
  input  wire logic        rst_b,   // synchronous reset, active low
  input  wire logic [31:0] period,  // cycle length in clocks
  output logic             tick     // one-cycle pulse at cycle end
);
  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } timer_s;
  timer_s st;
  timer_s next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count + 32'h1 >= period) begin
      next_st.count = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick = st.tick;
endmodule

/* File: rtl/monitor_rate_trim_result_regs.sv */
// Purpose: conversion-speed, ideality-trim and conversion-result registers
// Assumes: host port logic presents one-cycle read/write strobes, 16-bit data
// Notes:   i2c_mode picks field layout and reset values; results come from ADC
`timescale 1ns/1ps
// Notes on behaviour
// - The speed selector sits in bits 2..0 over SPI and bits 10..8 over I2C.
// - Selector 000 means 128x base speed, halving per step, 111 is base speed.
// - After reset the speed register reads 0007h over SPI and 07FFh over I2C.
// - Local sensor alone gives a 15 ms monitoring cycle.
// - One remote sensor alone gives 44 ms, or 93 ms with correction.
// - One remote plus local gives 59 ms, or 108 ms with correction.
// - Both remotes without local give 88 ms, or 186 ms with correction.
// - All three sensors give 103 ms, or 201 ms with correction.
// - Only the trim byte of each trim register matters, the other byte is ignored.
// - Trim registers sit at 21h and 22h, in bits 7..0 over SPI and 15..8 over I2C.
// - The trim code is a signed correction, 00h nominal, 7Fh largest, 80h smallest.
// - Sixteen read-only result registers at 23h..32h hold 12-bit results in bits 11..0.
// - Single-ended results are straight binary and reset to zero.
// - Differential pairs 0/1 and 2/3 store two's complement in results 0 and 2.
// - A correction enable bit selects the longer corrected cycle times.
// - Each sensor has an enable; a cleared one drops it from the cycle unless no remote is enabled, which keeps the 15 ms cycle.
module monitor_rate_trim_result_regs (
  input  wire logic        clk,                        // system clock, 125 MHz
  input  wire logic        rst_b,                      // synchronous reset, active low
  input  wire logic        i2c_mode,                   // 1: two-wire host layout
  input  wire logic [6:0]  reg_addr,                   // register address
  input  wire logic        reg_wr,                     // write strobe
  input  wire logic        reg_rd,                     // read strobe
  input  wire logic [15:0] reg_wdata,                  // write data
  input  wire logic        local_sense_en,             // local sensor enable
  input  wire logic        remote1_sense_en,           // remote sensor one enable
  input  wire logic        remote2_sense_en,           // remote sensor two enable
  input  wire logic        series_resistance_corr_en,  // correction enable
  input  wire logic        result_valid,               // new ADC result
  input  wire logic [3:0]  result_channel,             // channel of result
  input  wire logic [11:0] result_data,                // raw 12-bit result
  input  wire logic        diff_pair01,                // inputs 0/1 differential
  input  wire logic        diff_pair23,                // inputs 2/3 differential
  output logic [15:0]      reg_rdata,                  // read data
  output logic             reg_rvalid,                 // read data valid pulse
  output logic [2:0]       conversion_speed,           // active speed selector
  output logic [7:0]       remote1_trim_code,          // signed trim, sensor one
  output logic [7:0]       remote2_trim_code,          // signed trim, sensor two
  output logic [7:0]       speed_multiplier,           // 128 down to 1
  output logic             cycle_done                  // monitoring cycle end pulse
);
  import monitor_regs_pkg::*;

  localparam logic [31:0] CYC_LOCAL      = 32'(CYC_MS_LOCAL * MS_CYCLES);
  localparam logic [31:0] CYC_ONE        = 32'(CYC_MS_ONE * MS_CYCLES);
  localparam logic [31:0] CYC_ONE_RC     = 32'(CYC_MS_ONE_RC * MS_CYCLES);
  localparam logic [31:0] CYC_ONE_LOC    = 32'(CYC_MS_ONE_LOC * MS_CYCLES);
  localparam logic [31:0] CYC_ONE_LOC_RC = 32'(CYC_MS_ONE_LOC_RC * MS_CYCLES);
  localparam logic [31:0] CYC_TWO        = 32'(CYC_MS_TWO * MS_CYCLES);
  localparam logic [31:0] CYC_TWO_RC     = 32'(CYC_MS_TWO_RC * MS_CYCLES);
  localparam logic [31:0] CYC_ALL        = 32'(CYC_MS_ALL * MS_CYCLES);
  localparam logic [31:0] CYC_ALL_RC     = 32'(CYC_MS_ALL_RC * MS_CYCLES);

  typedef struct packed {
    logic [15:0]                    conv_speed_word;
    logic [15:0]                    trim1_word;
    logic [15:0]                    trim2_word;
    logic [RESULT_COUNT-1:0][11:0]  results;
    logic [15:0]                    rdata;
    logic                           rvalid;
    logic [2:0]                     speed;
    logic [7:0]                     trim1;
    logic [7:0]                     trim2;
    logic [7:0]                     mult;
    logic                           done;
  } regs_s;

  regs_s       st;
  regs_s       next_st;
  logic [31:0] cycle_period;
  logic        tick;
  logic [1:0]  remote_count;
  logic [6:0]  result_off;

  // cycle time from active sensors and correction option
  always_comb begin
    remote_count = {1'b0, remote1_sense_en} + {1'b0, remote2_sense_en};
    cycle_period = CYC_LOCAL;
    unique case (remote_count)
      2'd0: cycle_period = CYC_LOCAL;
      2'd1: begin
        if (local_sense_en) begin
          cycle_period = series_resistance_corr_en ? CYC_ONE_LOC_RC : CYC_ONE_LOC;
        end else begin
          cycle_period = series_resistance_corr_en ? CYC_ONE_RC : CYC_ONE;
        end
      end
      2'd2: begin
        if (local_sense_en) begin
          cycle_period = series_resistance_corr_en ? CYC_ALL_RC : CYC_ALL;
        end else begin
          cycle_period = series_resistance_corr_en ? CYC_TWO_RC : CYC_TWO;
        end
      end
      default: cycle_period = CYC_LOCAL;
    endcase
  end

  cycle_timer u_cycle_timer (
    .clk    (clk),
    .rst_b  (rst_b),
    .period (cycle_period),
    .tick   (tick)
  );

  assign result_off = reg_addr - ADDR_RESULT_FIRST;

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.done = tick;
    if (reg_wr) begin
      // whole word stored so reserved bits read back; only the field acts
      unique case (reg_addr)
        ADDR_CONV_SPEED: next_st.conv_speed_word = reg_wdata;
        ADDR_TRIM1:      next_st.trim1_word = reg_wdata;
        ADDR_TRIM2:      next_st.trim2_word = reg_wdata;
        default: ;  // results and unmapped addresses ignore writes
      endcase
    end
    if (result_valid) begin
      // differential pairs land in results 0 and 2 as two's complement
      next_st.results[result_channel] = result_data;
      if ((diff_pair01 && result_channel == 4'h1) || (diff_pair23 && result_channel == 4'h3)) begin
        next_st.results[result_channel] = st.results[result_channel];
      end
    end
    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 16'h0000;
      if (reg_addr == ADDR_CONV_SPEED) begin
        next_st.rdata = st.conv_speed_word;
      end else if (reg_addr == ADDR_TRIM1) begin
        next_st.rdata = st.trim1_word;
      end else if (reg_addr == ADDR_TRIM2) begin
        next_st.rdata = st.trim2_word;
      end else if (reg_addr >= ADDR_RESULT_FIRST && reg_addr <= ADDR_RESULT_LAST) begin
        next_st.rdata = {4'h0, st.results[result_off[3:0]]};
      end
    end
    // selector and trim taken from the field of the current layout
    next_st.speed = i2c_mode ? next_st.conv_speed_word[SPEED_LSB_I2C +: 3]
                             : next_st.conv_speed_word[SPEED_LSB_SPI +: 3];
    next_st.trim1 = i2c_mode ? next_st.trim1_word[TRIM_LSB_I2C +: 8]
                             : next_st.trim1_word[TRIM_LSB_SPI +: 8];
    next_st.trim2 = i2c_mode ? next_st.trim2_word[TRIM_LSB_I2C +: 8]
                             : next_st.trim2_word[TRIM_LSB_SPI +: 8];
    next_st.mult = 8'h80 >> next_st.speed;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      st.conv_speed_word <= i2c_mode ? CONV_SPEED_RST_I2C : CONV_SPEED_RST_SPI;
      st.trim1_word <= i2c_mode ? TRIM_RST_I2C : TRIM_RST_SPI;
      st.trim2_word <= i2c_mode ? TRIM_RST_I2C : TRIM_RST_SPI;
      st.results <= {RESULT_COUNT{RESULT_RST}};
      st.speed <= SPEED_BASE;
      st.mult <= 8'h01;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata         = st.rdata;
  assign reg_rvalid        = st.rvalid;
  assign conversion_speed  = st.speed;
  assign remote1_trim_code = st.trim1;
  assign remote2_trim_code = st.trim2;
  assign speed_multiplier  = st.mult;
  assign cycle_done        = st.done;
endmodule

/* File: verification/regs_properties.sv */
// Purpose: port checks for the rate, trim and result register slice
// Assumes: i2c_mode only changes while reset is held
// Notes:   bound to every instance of the slice
`timescale 1ns/1ps
module regs_properties (
  input wire logic        clk,               // clock
  input wire logic        rst_b,             // reset, active low
  input wire logic        i2c_mode,          // layout select
  input wire logic [6:0]  reg_addr,          // address
  input wire logic        reg_wr,            // write strobe
  input wire logic        reg_rd,            // read strobe
  input wire logic [15:0] reg_wdata,         // write data
  input wire logic        result_valid,      // new result
  input wire logic        reg_rvalid,        // read valid
  input wire logic [2:0]  conversion_speed,  // selector
  input wire logic [7:0]  remote1_trim_code, // trim one
  input wire logic [7:0]  remote2_trim_code, // trim two
  input wire logic [7:0]  speed_multiplier,  // multiplier
  input wire logic        cycle_done         // cycle end
);
  import monitor_regs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
  mult_map_a: assert property (speed_multiplier == (8'h80 >> conversion_speed)) else $error("bad multiplier");
  speed_spi_a: assert property (reg_wr && reg_addr == ADDR_CONV_SPEED && !i2c_mode
    |=> conversion_speed == $past(reg_wdata[2:0])) else $error("speed field not taken");
  speed_i2c_a: assert property (reg_wr && reg_addr == ADDR_CONV_SPEED && i2c_mode
    |=> conversion_speed == $past(reg_wdata[10:8])) else $error("speed field not taken");
  speed_hold_a: assert property (!(reg_wr && reg_addr == ADDR_CONV_SPEED) |=> $stable(conversion_speed))
    else $error("speed changed without write");
  trim_one_a: assert property (reg_wr && reg_addr == ADDR_TRIM1 |=> remote1_trim_code ==
    ($past(i2c_mode) ? $past(reg_wdata[15:8]) : $past(reg_wdata[7:0]))) else $error("trim one wrong");
  trim_two_a: assert property (reg_wr && reg_addr == ADDR_TRIM2 |=> remote2_trim_code ==
    ($past(i2c_mode) ? $past(reg_wdata[15:8]) : $past(reg_wdata[7:0]))) else $error("trim two wrong");
  done_pulse_a: assert property (cycle_done |=> !cycle_done) else $error("cycle end not a pulse");
  cover property (reg_rvalid);
  cover property (reg_wr && reg_addr == ADDR_TRIM2);
  cover property (result_valid);
endmodule
bind monitor_rate_trim_result_regs regs_properties chk_u (.clk(clk), .rst_b(rst_b), .i2c_mode(i2c_mode),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .result_valid(result_valid),
  .reg_rvalid(reg_rvalid), .conversion_speed(conversion_speed), .remote1_trim_code(remote1_trim_code),
  .remote2_trim_code(remote2_trim_code), .speed_multiplier(speed_multiplier), .cycle_done(cycle_done));

/* File: verification/host_model.sv */
// Purpose: host side of the register port, one request at a time
// Assumes: strobes are taken on the rising edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,        // clock
  input  wire logic [15:0] reg_rdata,  // read data
  input  wire logic        reg_rvalid, // read valid
  output logic [6:0]       reg_addr,   // address
  output logic             reg_wr,     // write strobe
  output logic             reg_rd,     // read strobe
  output logic [15:0]      reg_wdata   // write data
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic write(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic read(input logic [6:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
endmodule

/* File: verification/monitor_rate_trim_result_regs_test.sv */
// Purpose: self-checking bench for the rate, trim and result slice
// Assumes: run far shorter than the 15 ms shortest monitoring cycle
// Notes:   word model m holds what each address must read back
`timescale 1ns/1ps
module monitor_rate_trim_result_regs_test;
  import monitor_regs_pkg::*;
  logic        clk = 0, rst_b = 0, i2c_mode = 0, result_valid = 0, reg_wr, reg_rd, reg_rvalid, cycle_done;
  logic [3:0]  en = 4'h1, result_channel = 4'h0;
  logic [1:0]  dp = 2'h0;
  logic [11:0] result_data = 12'h000;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, got, m [0:127];
  logic [2:0]  conversion_speed;
  logic [7:0]  remote1_trim_code, remote2_trim_code, speed_multiplier, trims [4] = '{8'h00, 8'h7F, 8'h80, 8'h5A};
  int          n_errors = 0, tests_run = 0, cycles = 0, n_done = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycle_done === 1'b1) n_done <= n_done + 1;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  monitor_rate_trim_result_regs dut_u (.clk(clk), .rst_b(rst_b), .i2c_mode(i2c_mode), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .local_sense_en(en[0]), .remote1_sense_en(en[1]),
    .remote2_sense_en(en[2]), .series_resistance_corr_en(en[3]), .result_valid(result_valid),
    .result_channel(result_channel), .result_data(result_data), .diff_pair01(dp[0]), .diff_pair23(dp[1]),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conversion_speed(conversion_speed),
    .remote1_trim_code(remote1_trim_code), .remote2_trim_code(remote2_trim_code),
    .speed_multiplier(speed_multiplier), .cycle_done(cycle_done));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [6:0] a);
    host_u.read(a, got);
    chk("read word", m[a], got);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host_u.write(a, d);
    if (a == ADDR_CONV_SPEED || a == ADDR_TRIM1 || a == ADDR_TRIM2) m[a] = d;
  endtask
  task automatic outs;
    logic [15:0] s, t1, t2;
    s = m[ADDR_CONV_SPEED] >> (i2c_mode ? SPEED_LSB_I2C : SPEED_LSB_SPI);
    t1 = m[ADDR_TRIM1] >> (i2c_mode ? TRIM_LSB_I2C : TRIM_LSB_SPI);
    t2 = m[ADDR_TRIM2] >> (i2c_mode ? TRIM_LSB_I2C : TRIM_LSB_SPI);
    chk("speed", {13'h0000, s[2:0]}, {13'h0000, conversion_speed});
    chk("multiplier", 16'h0080 >> s[2:0], {8'h00, speed_multiplier});
    chk("trim one", {8'h00, t1[7:0]}, {8'h00, remote1_trim_code});
    chk("trim two", {8'h00, t2[7:0]}, {8'h00, remote2_trim_code});
  endtask
  task automatic pass(input logic mode);
    logic [15:0] w;
    @(negedge clk);
    rst_b = 0;
    i2c_mode = mode;
    repeat (20) @(negedge clk);
    rst_b = 1;
    foreach (m[a]) m[a] = 16'h0000;
    m[ADDR_CONV_SPEED] = mode ? CONV_SPEED_RST_I2C : CONV_SPEED_RST_SPI;
    m[ADDR_TRIM1] = mode ? TRIM_RST_I2C : TRIM_RST_SPI;
    m[ADDR_TRIM2] = m[ADDR_TRIM1];
    for (int a = 0; a < 64; a++) rd(a[6:0]);
    outs();
    for (int c = 0; c < 8; c++) begin
      w = 16'($urandom);
      if (mode) w[10:8] = c[2:0];
      else w[2:0] = c[2:0];
      wr(ADDR_CONV_SPEED, w);
      outs();
      rd(ADDR_CONV_SPEED);
    end
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom);
      if (mode) w[15:8] = trims[i % 4];
      else w[7:0] = trims[i % 4];
      wr(ADDR_TRIM1 + 7'(i % 2), w);
      outs();
      rd(ADDR_TRIM1 + 7'(i % 2));
    end
    for (int i = 0; i < 40; i++) begin
      w = 16'($urandom);
      {en, dp} = w[5:0];
      @(negedge clk);
      result_valid = 1;
      result_channel = (i < 16) ? 4'(i) : w[9:6];
      result_data = 12'($urandom);
      if (!((result_channel == 1 && dp[0]) || (result_channel == 3 && dp[1])))
        m[ADDR_RESULT_FIRST + 7'(result_channel)] = {4'h0, result_data};
      @(negedge clk);
      result_valid = 0;
      result_data = ~result_data;
      wr(ADDR_RESULT_FIRST + 7'(w[13:10]), w);
      rd(ADDR_RESULT_FIRST + 7'(result_channel));
      rd(ADDR_RESULT_FIRST + 7'(w[13:10]));
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8f93));
    pass(1'b0);
    pass(1'b1);
    chk("cycle ends", 16'h0000, 16'(n_done));
    wrap_up();
  end
endmodule
